// ---- slot_window_defs.svh ----
// Register indexes, field positions and codes for the slot power and I/O window bank
`ifndef SLOT_WINDOW_DEFS_SVH
`define SLOT_WINDOW_DEFS_SVH

// Register indexes within one slot, byte address is index times four
`define IDX_POWER_CTRL   6'h02
`define IDX_WIN_ENABLE   6'h06
`define IDX_WIN_CTRL     6'h07
`define IDX_W0_START_LO  6'h08
`define IDX_W0_START_HI  6'h09
`define IDX_W0_STOP_LO   6'h0a
`define IDX_W0_STOP_HI   6'h0b
`define IDX_W1_START_LO  6'h0c
`define IDX_W1_START_HI  6'h0d
`define IDX_W1_STOP_LO   6'h0e
`define IDX_W1_STOP_HI   6'h0f
`define IDX_SLOT_STATUS  6'h3e

// Index sits in address bits 9:2, slot number in index bits 7:6
`define ADDR_IDX_LSB     2
`define ADDR_IDX_MSB     9

// Power control fields
`define PWR_SUPPLY_5V    4
`define PWR_SUPPLY_3V    3
`define PWR_THRESH_5V    2
`define PWR_VPP_PGM      1
`define PWR_VPP_VCC      0
`define SUPPLY_5V_CODE   2'b10

// Window enable fields
`define WEN_IO0          6
`define WEN_IO1          7

// Window control nibble fields, window 1 nibble sits one stride higher
`define WCTL_SIZE        0
`define WCTL_SIZE_SRC    1
`define WCTL_ZERO_WAIT   2
`define WCTL_EXTRA_WAIT  3
`define WCTL_STRIDE      4

`define REG_RESET        8'h00
`define AXI_RESP_OKAY    2'b00
`define AXI_RESP_SLVERR  2'b10

`endif

// ---- slot_window_pkg.sv ----
// Types shared by the slot power and I/O window bank
package slot_window_pkg;

	typedef struct packed {
		logic [7:0]       power;
		logic [7:0]       win_enable;
		logic [7:0]       win_ctrl;
		logic [1:0][15:0] start;
		logic [1:0][15:0] stop;
		logic             aw_held;
		logic             aw_ok;
		logic [5:0]       aw_off;
		logic             w_held;
		logic             w_lane;
		logic [7:0]       w_data;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [7:0]       rdata;
		logic             sel_5v;
		logic             sel_3v;
		logic             vpp_pgm;
		logic             vpp_vcc;
		logic             thresh_5v;
		logic             claim;
		logic             claim_win;
		logic             cyc16;
		logic             zero_wait;
		logic             extra_wait;
	} slot_state_s;

endpackage

// ---- pin_sync.sv ----
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
	parameter int         WIDTH       = 1,
	parameter logic [WIDTH-1:0] RESET_LEVEL = '1
) (
	// Clock and reset
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	// Pins in, clean levels out
	input  wire logic [WIDTH-1:0] pin_in,
	output logic      [WIDTH-1:0] level_out
);

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] level;
	} sync_state_s;

	sync_state_s state_reg;
	sync_state_s state_next;

	always_comb
	begin
		state_next    = state_reg;
		state_next.s1 = pin_in;
		state_next.s2 = state_reg.s1;
		state_next.s3 = state_reg.s2;
		for (int i = 0; i < WIDTH; i++)
		begin
			if (state_reg.s2[i] == state_reg.s3[i])
			begin
				state_next.level[i] = state_reg.s2[i];
			end
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= {4{RESET_LEVEL}};
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	assign level_out = state_reg.level;

endmodule
`default_nettype wire

// ---- slot_power_io_windows.sv ----
// Slot power pins, threshold select and two I/O mapping windows behind AXI4-Lite
//
// Chosen here: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
`include "slot_window_defs.svh"

module slot_power_io_windows #(
	parameter logic [1:0] SLOT_NUMBER = 2'b00
) (
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        rst_n,
	// AXI4-Lite write address
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	// AXI4-Lite write data
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	// AXI4-Lite read address
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	// Card and power switch pins
	input  wire logic        card_voltage_sense_two,
	input  wire logic        card_io_is16_n,
	output logic             card_supply_5v_select,
	output logic             card_supply_3v_select,
	output logic             vpp_program_select,
	output logic             vpp_follow_supply_select,
	output logic             slot_threshold_5v,
	// Host I/O access decode
	input  wire logic        host_io_valid,
	input  wire logic [15:0] host_io_addr,
	output logic             io_claim,
	output logic             io_claim_window,
	output logic             io_cycle_16bit,
	output logic             io_zero_wait,
	output logic             io_extra_wait
);

	// ************************************************************
	// Functions
	// ************************************************************

	function automatic logic in_window(input logic [15:0] addr,
		input logic [15:0] lo, input logic [15:0] hi);
		in_window = (addr >= lo) && (addr <= hi);
	endfunction

	// Splits a bus address into slot-local offset and a hit flag
	function automatic logic [6:0] decode_addr(input logic [31:0] addr);
		logic [7:0] idx;
		logic       hit;
		idx = addr[`ADDR_IDX_MSB:`ADDR_IDX_LSB];
		hit = (addr[31:`ADDR_IDX_MSB+1] == '0) && (idx[7:6] == SLOT_NUMBER)
			&& (addr[`ADDR_IDX_LSB-1:0] == '0);
		decode_addr = {hit, idx[5:0]};
	endfunction

	function automatic logic off_mapped(input logic [5:0] off);
		case (off)
			`IDX_POWER_CTRL, `IDX_WIN_ENABLE, `IDX_WIN_CTRL,
			`IDX_W0_START_LO, `IDX_W0_START_HI, `IDX_W0_STOP_LO, `IDX_W0_STOP_HI,
			`IDX_W1_START_LO, `IDX_W1_START_HI, `IDX_W1_STOP_LO, `IDX_W1_STOP_HI,
			`IDX_SLOT_STATUS: off_mapped = 1'b1;
			default:          off_mapped = 1'b0;
		endcase
	endfunction

	// ************************************************************
	// Pin synchronisers
	// ************************************************************

	logic [1:0] pin_level;
	logic       sense_grounded;
	logic       card_wants16;

	pin_sync #(
		.WIDTH       (2),
		.RESET_LEVEL (2'b11)
	) pin_sync_inst (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.pin_in    ({card_io_is16_n, card_voltage_sense_two}),
		.level_out (pin_level)
	);

	assign sense_grounded = !pin_level[0];
	assign card_wants16   = !pin_level[1];

	// ************************************************************
	// State
	// ************************************************************

	slot_window_pkg::slot_state_s state_reg;
	slot_window_pkg::slot_state_s state_next;

	logic       aw_fire;
	logic       w_fire;
	logic       ar_fire;
	logic       lockout;
	logic [7:0] status_byte;

	assign s_axi_awready = !state_reg.aw_held && !state_reg.bvalid;
	assign s_axi_wready  = !state_reg.w_held && !state_reg.bvalid;
	assign s_axi_arready = !state_reg.rvalid;
	assign aw_fire       = s_axi_awvalid && s_axi_awready;
	assign w_fire        = s_axi_wvalid && s_axi_wready;
	assign ar_fire       = s_axi_arvalid && s_axi_arready;

	// Guards a card that cannot take 5V
	assign lockout = sense_grounded
		&& (state_reg.power[`PWR_SUPPLY_5V:`PWR_SUPPLY_3V] == `SUPPLY_5V_CODE);

	assign status_byte = {3'h0, state_reg.cyc16, state_reg.claim_win,
		card_wants16, lockout, sense_grounded};

	always_comb
	begin
		logic [6:0] dec;
		logic [5:0] roff;
		logic [7:0] rval;
		logic       hit0;
		logic       hit1;
		logic [3:0] nib;
		dec        = '0;
		roff       = '0;
		rval       = '0;
		hit0       = 1'b0;
		hit1       = 1'b0;
		nib        = '0;
		state_next = state_reg;

		// Write channel capture, address and data in either order
		if (aw_fire)
		begin
			dec                 = decode_addr(s_axi_awaddr);
			state_next.aw_held  = 1'b1;
			state_next.aw_off   = dec[5:0];
			state_next.aw_ok    = dec[6] && off_mapped(dec[5:0]);
		end
		if (w_fire)
		begin
			state_next.w_held = 1'b1;
			state_next.w_data = s_axi_wdata[7:0];
			state_next.w_lane = s_axi_wstrb[0];
		end
		if (state_reg.bvalid && s_axi_bready)
		begin
			state_next.bvalid = 1'b0;
		end

		// Commit once both halves are held; status is read-only
		if (state_reg.aw_held && state_reg.w_held)
		begin
			state_next.aw_held = 1'b0;
			state_next.w_held  = 1'b0;
			state_next.bvalid  = 1'b1;
			state_next.bresp   = state_reg.aw_ok ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
			if (state_reg.aw_ok && state_reg.w_lane)
			begin
				unique case (state_reg.aw_off)
					`IDX_POWER_CTRL:  state_next.power       = state_reg.w_data;
					`IDX_WIN_ENABLE:  state_next.win_enable  = state_reg.w_data;
					`IDX_WIN_CTRL:    state_next.win_ctrl    = state_reg.w_data;
					`IDX_W0_START_LO: state_next.start[0][7:0]  = state_reg.w_data;
					`IDX_W0_START_HI: state_next.start[0][15:8] = state_reg.w_data;
					`IDX_W0_STOP_LO:  state_next.stop[0][7:0]   = state_reg.w_data;
					`IDX_W0_STOP_HI:  state_next.stop[0][15:8]  = state_reg.w_data;
					`IDX_W1_START_LO: state_next.start[1][7:0]  = state_reg.w_data;
					`IDX_W1_START_HI: state_next.start[1][15:8] = state_reg.w_data;
					`IDX_W1_STOP_LO:  state_next.stop[1][7:0]   = state_reg.w_data;
					`IDX_W1_STOP_HI:  state_next.stop[1][15:8]  = state_reg.w_data;
					default:          state_next.power       = state_reg.power;
				endcase
			end
		end

		// Read channel, answer one cycle after the address is taken
		if (state_reg.rvalid && s_axi_rready)
		begin
			state_next.rvalid = 1'b0;
		end
		if (ar_fire)
		begin
			dec  = decode_addr(s_axi_araddr);
			roff = dec[5:0];
			case (roff)
				`IDX_POWER_CTRL:  rval = state_reg.power;
				`IDX_WIN_ENABLE:  rval = state_reg.win_enable;
				`IDX_WIN_CTRL:    rval = state_reg.win_ctrl;
				`IDX_W0_START_LO: rval = state_reg.start[0][7:0];
				`IDX_W0_START_HI: rval = state_reg.start[0][15:8];
				`IDX_W0_STOP_LO:  rval = state_reg.stop[0][7:0];
				`IDX_W0_STOP_HI:  rval = state_reg.stop[0][15:8];
				`IDX_W1_START_LO: rval = state_reg.start[1][7:0];
				`IDX_W1_START_HI: rval = state_reg.start[1][15:8];
				`IDX_W1_STOP_LO:  rval = state_reg.stop[1][7:0];
				`IDX_W1_STOP_HI:  rval = state_reg.stop[1][15:8];
				`IDX_SLOT_STATUS: rval = status_byte;
				default:          rval = '0;
			endcase
			state_next.rvalid = 1'b1;
			state_next.rdata  = dec[6] ? rval : '0;
			state_next.rresp  = (dec[6] && off_mapped(roff)) ? `AXI_RESP_OKAY
				: `AXI_RESP_SLVERR;
		end

		// Supply pins straight from the bits unless the lockout forces both low
		state_next.sel_5v    = state_reg.power[`PWR_SUPPLY_5V] && !lockout;
		state_next.sel_3v    = state_reg.power[`PWR_SUPPLY_3V] && !lockout;
		state_next.vpp_pgm   = state_reg.power[`PWR_VPP_PGM];
		state_next.vpp_vcc   = state_reg.power[`PWR_VPP_VCC];
		state_next.thresh_5v = state_reg.power[`PWR_THRESH_5V];

		// Window 0 wins when ranges overlap
		hit0 = host_io_valid && state_reg.win_enable[`WEN_IO0]
			&& in_window(host_io_addr, state_reg.start[0], state_reg.stop[0]);
		hit1 = host_io_valid && state_reg.win_enable[`WEN_IO1]
			&& in_window(host_io_addr, state_reg.start[1], state_reg.stop[1]);
		nib  = hit0 ? state_reg.win_ctrl[`WCTL_STRIDE-1:0]
			: state_reg.win_ctrl[2*`WCTL_STRIDE-1:`WCTL_STRIDE];
		state_next.claim     = hit0 || hit1;
		state_next.claim_win = !hit0 && hit1;
		state_next.cyc16     = 1'b0;
		state_next.zero_wait = 1'b0;
		state_next.extra_wait = 1'b0;
		if (hit0 || hit1)
		begin
			state_next.cyc16 = nib[`WCTL_SIZE_SRC] ? card_wants16
				: nib[`WCTL_SIZE];
			state_next.zero_wait  = nib[`WCTL_ZERO_WAIT] && !state_next.cyc16;
			state_next.extra_wait = nib[`WCTL_EXTRA_WAIT];
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
		end
	end

	// ************************************************************
	// Outputs
	// ************************************************************

	assign s_axi_bvalid             = state_reg.bvalid;
	assign s_axi_bresp              = state_reg.bresp;
	assign s_axi_rvalid             = state_reg.rvalid;
	assign s_axi_rresp              = state_reg.rresp;
	assign s_axi_rdata              = {24'h0, state_reg.rdata};
	assign card_supply_5v_select    = state_reg.sel_5v;
	assign card_supply_3v_select    = state_reg.sel_3v;
	assign vpp_program_select       = state_reg.vpp_pgm;
	assign vpp_follow_supply_select = state_reg.vpp_vcc;
	assign slot_threshold_5v        = state_reg.thresh_5v;
	assign io_claim                 = state_reg.claim;
	assign io_claim_window          = state_reg.claim_win;
	assign io_cycle_16bit           = state_reg.cyc16;
	assign io_zero_wait             = state_reg.zero_wait;
	assign io_extra_wait            = state_reg.extra_wait;

	// ************************************************************
	// Checks
	// ************************************************************

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!rst_n);

	sequence write_taken;
		state_reg.aw_held && state_reg.w_held;
	endsequence

	sequence write_answered;
		s_axi_bvalid && !s_axi_awready && !s_axi_wready;
	endsequence

	chk_supply_follow: assert property (
		!lockout |=> {card_supply_5v_select, card_supply_3v_select}
			== $past(state_reg.power[`PWR_SUPPLY_5V:`PWR_SUPPLY_3V]))
		else $error("Supply pins differ from power bits");

	chk_vpp_follow: assert property (
		##1 {vpp_program_select, vpp_follow_supply_select}
			== $past(state_reg.power[`PWR_VPP_PGM:`PWR_VPP_VCC]))
		else $error("Vpp pins differ from power bits");

	chk_five_volt_lock: assert property (
		(sense_grounded && state_reg.power[`PWR_SUPPLY_5V:`PWR_SUPPLY_3V] == `SUPPLY_5V_CODE)
			|=> !card_supply_5v_select && !card_supply_3v_select)
		else $error("5V applied to low-voltage card");

	chk_threshold_bit: assert property (
		$changed(state_reg.power[`PWR_THRESH_5V]) |=> slot_threshold_5v
			== $past(state_reg.power[`PWR_THRESH_5V]))
		else $error("Threshold does not follow its bit");

	chk_window_claim: assert property (
		(host_io_valid && state_reg.win_enable[`WEN_IO1]
			&& in_window(host_io_addr, state_reg.start[1], state_reg.stop[1]))
			|=> io_claim)
		else $error("Access inside window not claimed");

	chk_no_stray_claim: assert property (
		!host_io_valid |=> !io_claim)
		else $error("Claim without host access");

	chk_fixed_size: assert property (
		(host_io_valid && state_reg.win_enable[`WEN_IO0]
			&& in_window(host_io_addr, state_reg.start[0], state_reg.stop[0])
			&& !state_reg.win_ctrl[`WCTL_SIZE_SRC])
			|=> io_cycle_16bit == $past(state_reg.win_ctrl[`WCTL_SIZE]))
		else $error("Window 0 data size wrong");

	chk_pin_size: assert property (
		(io_claim && !io_claim_window && $past(state_reg.win_ctrl[`WCTL_SIZE_SRC]))
			|-> io_cycle_16bit == $past(card_wants16))
		else $error("Card size pin ignored");

	chk_zero_wait_8bit: assert property (
		io_zero_wait |-> io_claim && !io_cycle_16bit)
		else $error("Zero wait on a 16-bit cycle");

	chk_extra_wait: assert property (
		(io_claim && io_claim_window) |-> io_extra_wait
			== $past(state_reg.win_ctrl[`WCTL_STRIDE+`WCTL_EXTRA_WAIT]))
		else $error("Extra wait bit of window 1 ignored");

	chk_write_answer: assert property (
		write_taken |=> write_answered)
		else $error("Write not answered one cycle after capture");

endmodule
`default_nettype wire

// ---- card_slot_model.sv ----
// Behavioural PC Card and card power switch as seen from the slot pins
`timescale 1ns/1ps
`default_nettype none

module card_slot_model (
	// Card kind chosen by the bench
	input  wire logic low_voltage_card,
	input  wire logic wants_16bit,
	// Power switch controls from the slot
	input  wire logic card_supply_5v_select,
	input  wire logic card_supply_3v_select,
	// Card pins and the supply the card sees
	output logic      card_voltage_sense_two,
	output logic      card_io_is16_n,
	output logic      five_volt_applied
);
	// ************
	// Card pins
	// ************
	// A 3.3V-only card grounds its second sense pin, so the line reads low
	assign card_voltage_sense_two = !low_voltage_card;
	assign card_io_is16_n         = !wants_16bit;
	// The switch gives 5V only for select code 10; a low voltage card must never see it
	assign five_volt_applied      = card_supply_5v_select && !card_supply_3v_select;
endmodule

`default_nettype wire

// ---- tb_top.sv ----
// Self-checking bench for the slot power pins and I/O window bank
`timescale 1ns/1ps
`default_nettype none
`include "slot_window_defs.svh"

module tb_top;
	// ************
	// Signals
	// ************
	logic        clk_sys, rst_n;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0]  s_axi_wstrb;
	logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic [1:0]  s_axi_bresp, s_axi_rresp;
	logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic        s_axi_rvalid, s_axi_rready;
	logic        card_voltage_sense_two, card_io_is16_n, five_volt_applied;
	logic        card_supply_5v_select, card_supply_3v_select;
	logic        vpp_program_select, vpp_follow_supply_select, slot_threshold_5v;
	logic        host_io_valid, io_claim, io_claim_window, io_cycle_16bit;
	logic        io_zero_wait, io_extra_wait, io_d, pin_probe;
	logic [15:0] host_io_addr, s0, e0, s1, e1;
	logic        low_voltage_card, wants_16bit;
	logic [7:0]  ctl, v;
	logic [1:0]  en;
	logic [7:0]  wv[8];
	logic [15:0] probes[8];
	logic [1:0]  exp_b[$];
	logic [33:0] exp_r[$];
	logic [4:0]  exp_io[$];
	logic [5:0]  exp_pin[$];
	int          fails = 0;
	int          samples_checked = 0;
	int          cycles = 0;
	int          seed;

	initial clk_sys = 1'b0;
	always #2 clk_sys = ~clk_sys;

	slot_power_io_windows #(.SLOT_NUMBER(2'b00)) slot_power_io_windows_inst (
		.clk_sys                  (clk_sys),
		.rst_n                    (rst_n),
		.s_axi_awaddr             (s_axi_awaddr),
		.s_axi_awvalid            (s_axi_awvalid),
		.s_axi_awready            (s_axi_awready),
		.s_axi_wdata              (s_axi_wdata),
		.s_axi_wstrb              (s_axi_wstrb),
		.s_axi_wvalid             (s_axi_wvalid),
		.s_axi_wready             (s_axi_wready),
		.s_axi_bresp              (s_axi_bresp),
		.s_axi_bvalid             (s_axi_bvalid),
		.s_axi_bready             (s_axi_bready),
		.s_axi_araddr             (s_axi_araddr),
		.s_axi_arvalid            (s_axi_arvalid),
		.s_axi_arready            (s_axi_arready),
		.s_axi_rdata              (s_axi_rdata),
		.s_axi_rresp              (s_axi_rresp),
		.s_axi_rvalid             (s_axi_rvalid),
		.s_axi_rready             (s_axi_rready),
		.card_voltage_sense_two   (card_voltage_sense_two),
		.card_io_is16_n           (card_io_is16_n),
		.card_supply_5v_select    (card_supply_5v_select),
		.card_supply_3v_select    (card_supply_3v_select),
		.vpp_program_select       (vpp_program_select),
		.vpp_follow_supply_select (vpp_follow_supply_select),
		.slot_threshold_5v        (slot_threshold_5v),
		.host_io_valid            (host_io_valid),
		.host_io_addr             (host_io_addr),
		.io_claim                 (io_claim),
		.io_claim_window          (io_claim_window),
		.io_cycle_16bit           (io_cycle_16bit),
		.io_zero_wait             (io_zero_wait),
		.io_extra_wait            (io_extra_wait)
	);

	card_slot_model card_slot_model_inst (
		.low_voltage_card       (low_voltage_card),
		.wants_16bit            (wants_16bit),
		.card_supply_5v_select  (card_supply_5v_select),
		.card_supply_3v_select  (card_supply_3v_select),
		.card_voltage_sense_two (card_voltage_sense_two),
		.card_io_is16_n         (card_io_is16_n),
		.five_volt_applied      (five_volt_applied)
	);

	// ************
	// Checking
	// ************
	task automatic note(input logic ok, input string what);
		samples_checked++;
		if (!ok)
		begin
			fails++;
			$display("Error at %0t: %s mismatch", $time, what);
		end
	endtask

	task automatic cmp_b(input logic [1:0] got);
		note(exp_b.size() > 0 && got === exp_b.pop_front(), "write response");
	endtask

	task automatic cmp_r(input logic [33:0] got);
		note(exp_r.size() > 0 && got === exp_r.pop_front(), "read data");
	endtask

	task automatic cmp_io(input logic [4:0] got);
		note(exp_io.size() > 0 && got === exp_io.pop_front(), "io decode");
	endtask

	task automatic cmp_pin(input logic [5:0] got);
		note(exp_pin.size() > 0 && got === exp_pin.pop_front(), "power pins");
	endtask

	// Results are matched to the oldest note as they appear at the ports
	always @(posedge clk_sys)
	begin
		io_d <= host_io_valid;
		if (s_axi_bvalid === 1'b1 && s_axi_bready)
			cmp_b(s_axi_bresp);
		if (s_axi_rvalid === 1'b1 && s_axi_rready)
			cmp_r({s_axi_rresp, s_axi_rdata});
		if (io_d)
			cmp_io({io_claim, io_claim_window, io_cycle_16bit,
				io_zero_wait, io_extra_wait});
		if (pin_probe)
			cmp_pin({card_supply_5v_select, card_supply_3v_select,
				vpp_program_select, vpp_follow_supply_select,
				slot_threshold_5v, five_volt_applied});
	end

	always @(posedge clk_sys)
	begin
		cycles++;
		if (cycles == 40000)
		begin
			fails++;
			$display("Error at %0t: run did not finish", $time);
			summarize();
		end
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", samples_checked, fails);
		if (fails == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ************
	// Bus and pin drivers
	// ************
	task automatic axi_wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		bit aw_done;
		bit w_done;
		aw_done = 0;
		w_done = 0;
		exp_b.push_back(resp);
		@(posedge clk_sys);
		s_axi_awaddr <= {22'h0, idx, 2'b00};
		s_axi_wdata <= {24'h0, d};
		s_axi_wstrb <= 4'h1;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do
		begin
			@(posedge clk_sys);
			if (!aw_done && s_axi_awready === 1'b1)
			begin
				aw_done = 1;
				s_axi_awvalid <= 1'b0;
			end
			if (!w_done && s_axi_wready === 1'b1)
			begin
				w_done = 1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(aw_done && w_done));
		do @(posedge clk_sys); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask

	task automatic axi_rd(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] resp);
		exp_r.push_back({resp, 24'h0, d});
		@(posedge clk_sys);
		s_axi_araddr <= {22'h0, idx, 2'b00};
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk_sys); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk_sys); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask

	task automatic pins(input logic [4:0] p, input logic grounded);
		logic [5:0] e;
		e = {p[4], p[3], p[1], p[0], p[2], 1'b0};
		if (grounded && p[4:3] == `SUPPLY_5V_CODE)
			e[5:4] = 2'b00;
		e[0] = e[5] && !e[4];
		axi_wr(8'(`IDX_POWER_CTRL), {3'h0, p}, `AXI_RESP_OKAY);
		// Pins follow one edge after the store, which lands on the same edge as bvalid
		repeat (2) @(posedge clk_sys);
		exp_pin.push_back(e);
		pin_probe <= 1'b1;
		@(posedge clk_sys);
		pin_probe <= 1'b0;
	endtask

	task automatic io_at(input logic [15:0] a);
		logic       h0;
		logic       h1;
		logic       c16;
		logic [3:0] nib;
		h0 = en[0] && a >= s0 && a <= e0;
		h1 = en[1] && a >= s1 && a <= e1;
		nib = h0 ? ctl[3:0] : ctl[7:4];
		c16 = nib[`WCTL_SIZE_SRC] ? wants_16bit : nib[`WCTL_SIZE];
		@(posedge clk_sys);
		host_io_valid <= 1'b1;
		host_io_addr <= a;
		if (h0 || h1)
			exp_io.push_back({1'b1, !h0, c16, nib[`WCTL_ZERO_WAIT] && !c16, nib[3]});
		else
			exp_io.push_back(5'h00);
	endtask

	// ************
	// Sequence
	// ************
	initial
	begin
		seed = 22;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_wstrb} = '0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{host_io_valid, host_io_addr, low_voltage_card, wants_16bit, pin_probe} = '0;
		rst_n = 1'b0;
		repeat (8) @(posedge clk_sys);
		rst_n <= 1'b1;
		axi_rd(8'(`IDX_POWER_CTRL), `REG_RESET, `AXI_RESP_OKAY);
		for (int i = 6; i < 16; i++)
			axi_rd(8'(i), `REG_RESET, `AXI_RESP_OKAY);
		$display("test reset values done");
		for (int i = 7; i < 16; i++)
		begin
			v = 8'($random(seed));
			if (i == 7)
				ctl = v;
			else
				wv[i - 8] = v;
			axi_wr(8'(i), v, `AXI_RESP_OKAY);
		end
		axi_wr(8'h47, 8'h5a, `AXI_RESP_SLVERR);
		axi_rd(8'h47, 8'h00, `AXI_RESP_SLVERR);
		axi_rd(8'h05, 8'h00, `AXI_RESP_SLVERR);
		axi_rd(8'(`IDX_WIN_CTRL), ctl, `AXI_RESP_OKAY);
		for (int i = 8; i < 16; i++)
			axi_rd(8'(i), wv[i - 8], `AXI_RESP_OKAY);
		$display("test register map done");
		for (int p = 0; p < 32; p++)
			pins(5'(p), 1'b0);
		low_voltage_card <= 1'b1;
		repeat (8) @(posedge clk_sys);
		for (int p = 0; p < 32; p++)
			pins(5'(p), 1'b1);
		// Status: sense grounded and lockout active while the 5V code is held
		pins(5'h10, 1'b1);
		axi_rd(8'(`IDX_SLOT_STATUS), 8'h03, `AXI_RESP_OKAY);
		pins(5'h08, 1'b1);
		axi_rd(8'(`IDX_SLOT_STATUS), 8'h01, `AXI_RESP_OKAY);
		$display("test power pins done");
		s0 = {8'h01, 8'($random(seed))};
		e0 = s0 + 16'h0040;
		s1 = {8'h80, 8'($random(seed))};
		e1 = s1 + 16'h0020;
		wv = '{s0[7:0], s0[15:8], e0[7:0], e0[15:8], s1[7:0], s1[15:8], e1[7:0], e1[15:8]};
		for (int i = 0; i < 8; i++)
			axi_wr(8'(8 + i), wv[i], `AXI_RESP_OKAY);
		probes = '{s0, e0, s0 - 16'h1, e0 + 16'h1, s1, e1, e1 + 16'h1, s1 - 16'h1};
		for (int k = 0; k < 4; k++)
			for (int j = 0; j < 12; j++)
			begin
				en = 2'(k);
				ctl = 8'($random(seed));
				wants_16bit <= j[0];
				axi_wr(8'(`IDX_WIN_ENABLE), {en, 6'h00}, `AXI_RESP_OKAY);
				axi_wr(8'(`IDX_WIN_CTRL), ctl, `AXI_RESP_OKAY);
				repeat (6) @(posedge clk_sys);
				foreach (probes[i])
					io_at(probes[i]);
				@(posedge clk_sys);
				host_io_valid <= 1'b0;
			end
		$display("test io windows done");
		repeat (4) @(posedge clk_sys);
		note(exp_b.size() + exp_r.size() + exp_io.size() + exp_pin.size() == 0, "result count");
		summarize();
	end
endmodule

`default_nettype wire
